// ==== include/diag_pkg.sv ====
// Constants for the diagnostic mode select and error display block
package diag_pkg;
    // Wishbone byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_CODE = 4'h8;
    localparam logic [3:0] OFS_CSR  = 4'hC;
    // Control register fields and reset value
    localparam int         CTRL_INIT    = 0;
    localparam int         CTRL_LAMP_EN = 1;
    localparam logic [1:0] CTRL_RST     = 2'h2;
    // Status register fields
    localparam int STAT_CODE  = 0;
    localparam int STAT_DRIVE = 5;
    localparam int STAT_BOTH  = 6;
    localparam int STAT_DIAG  = 7;
    localparam int STAT_HALT  = 8;
    localparam int STAT_CLASS = 9;
    // Command status error flag position
    localparam int CSR_ERR = 15;
    // Switch bank layout: bit 7 is position one
    localparam int SW_MODE_HI = 7;
    localparam int SW_MODE_LO = 5;
    localparam int SW_CODE_LO = 3;
    localparam int SW_DRIVE   = 0;
    // Test codes
    localparam logic [4:0] TC_ECHO     = 5'h10;
    localparam logic [4:0] TC_EXER_FMT = 5'h1E;
    localparam logic [4:0] TC_EXER     = 5'h1F;
    // Cycles after reset release before the switches are latched
    localparam logic [1:0] CAPTURE_WAIT = 2'h2;
    // Error classes
    localparam logic [3:0] CL_NONE = 4'h0, CL_OPER = 4'h1, CL_UNAS2 = 4'h2, CL_HOST = 4'h3;
    localparam logic [3:0] CL_DCAB = 4'h4, CL_DENS = 4'h5, CL_SEEK = 4'h6, CL_UNAS7 = 4'h7;
    localparam logic [3:0] CL_DCRC = 4'h8, CL_SECT = 4'h9, CL_RDAT = 4'hA, CL_RWC = 4'hB;
    localparam logic [3:0] CL_MST = 4'hC, CL_DRV = 4'hD, CL_PAT = 4'hE, CL_WFMT = 4'hF;
    // Octal error codes held as bytes
    localparam logic [7:0] EC_HOME0 = 8'h08, EC_HOME1 = 8'h10, EC_TRK0IN = 8'h18, EC_ADDR = 8'h20;
    localparam logic [7:0] EC_TRK0 = 8'h28, EC_NOSECT = 8'h38, EC_WPROT = 8'h40, EC_NORD = 8'h48;
    localparam logic [7:0] EC_NOPRE = 8'h50, EC_NOID = 8'h58, EC_HCRC = 8'h60, EC_MISM = 8'h68;
    localparam logic [7:0] EC_IDTRY = 8'h70, EC_NODAM = 8'h78, EC_DCRC = 8'h80, EC_PAR = 8'h88;
    localparam logic [7:0] EC_RWST = 8'h90, EC_WCNT = 8'h98, EC_DENS = 8'hA0, EC_KEY = 8'hA8;
    localparam logic [7:0] EC_INDET = 8'hB0, EC_WFMT = 8'hB8, EC_RWWR = 8'hD0, EC_RWTO = 8'hD8;
    localparam logic [7:0] EC_SYNC = 8'hE0, EC_NXM = 8'hE8, EC_NRDY = 8'hF0, EC_ACLOW = 8'hF8;
endpackage

// ==== design/error_classifier.sv ====
// Maps a recorded error code onto its displayed error class
`timescale 1ns/10ps
module error_classifier
    import diag_pkg::*;
(
    // Code in
    input  wire logic [7:0] code_i,
    input  wire logic       diag_i,
    // Result
    output logic            valid_o,
    output logic [3:0]      class_o,
    output logic            flag_o
);
    // Class lookup, zero class when unknown
    function automatic logic [3:0] class_of(input logic [7:0] c);
        case (c)
            EC_WPROT, EC_NRDY:                       class_of = CL_OPER;
            EC_INDET:                                class_of = CL_DENS;
            EC_MISM:                                 class_of = CL_SEEK;
            EC_DCRC:                                 class_of = CL_DCRC;
            EC_NOSECT, EC_NOPRE, EC_NOID, EC_IDTRY,
            EC_NODAM:                                class_of = CL_SECT;
            EC_NORD:                                 class_of = CL_RDAT;
            EC_RWST, EC_RWWR, EC_RWTO:               class_of = CL_RWC;
            EC_SYNC:                                 class_of = CL_MST;
            EC_HOME0, EC_HOME1, EC_TRK0IN, EC_TRK0:  class_of = CL_DRV;
            EC_WFMT, EC_ACLOW:                       class_of = CL_WFMT;
            EC_ADDR:                                 class_of = CL_HOST;
            EC_DENS, EC_KEY:                         class_of = CL_UNAS2;
            EC_WCNT, EC_NXM:                         class_of = CL_DCAB;
            EC_HCRC:                                 class_of = CL_UNAS7;
            EC_PAR:                                  class_of = CL_PAT;
            default:                                 class_of = CL_NONE;
        endcase
    endfunction

    // Host-side codes carry no meaning while diagnosing
    logic host_only;
    assign host_only = (code_i == EC_PAR) || (code_i == EC_WCNT) || (code_i == EC_NXM)
                    || (code_i == EC_ADDR) || (code_i == EC_DENS) || (code_i == EC_KEY)
                    || (code_i == EC_HCRC);
    assign class_o = class_of(code_i);
    // Host codes and unassigned classes never reach the lamps in diagnostics
    assign valid_o = (class_o != CL_NONE) && !(diag_i && host_only);
    // Two codes leave the command status error flag alone
    assign flag_o  = (code_i != EC_HOME1) && (code_i != EC_HCRC);
endmodule

// ==== design/diag_mode_select_and_error_display.sv ====
// Diagnostic mode select, lamp driver and error class display
`timescale 1ns/10ps
module diag_mode_select_and_error_display
    import diag_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Operator switch bank and drive pins
    input  wire logic [7:0]  sw_i,
    input  wire logic [1:0]  head_loaded_i,
    // Controller activity, same clock
    input  wire logic        selftest_busy_i,
    input  wire logic        write_busy_i,
    input  wire logic        read_busy_i,
    input  wire logic        host_wait_i,
    input  wire logic [1:0]  density_i,
    input  wire logic        pass_done_i,
    // Error events, same clock
    input  wire logic        err_valid_i,
    input  wire logic [7:0]  err_code_i,
    input  wire logic        mismatch_i,
    input  wire logic        host_cable_fault_i,
    input  wire logic        drive_cable_fault_i,
    // Lamps
    output logic      [7:0]  lamp_o,
    output logic             run_lamp_o,
    output logic      [1:0]  drive_act_o,
    // Selection outputs
    output logic             diag_mode_o,
    output logic      [4:0]  test_code_o,
    output logic             drive_sel_o,
    output logic             exercise_both_o
);
    // Controller states
    typedef enum logic [2:0]
    {
        ST_WAIT = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } state_e;

    state_e      state_q;      // Controller state
    logic [1:0]  wait_q;       // Cycles since reset release
    logic [7:0]  sw_m_q;       // Switch synchroniser first stage
    logic [7:0]  sw_s_q;       // Switch synchronised
    logic [1:0]  hl_m_q;       // Head loaded first stage
    logic [1:0]  hl_s_q;       // Head loaded synchronised
    logic        sw8_q;        // Latched switch eight
    logic [3:0]  class_q;      // Displayed error class
    logic [7:0]  err_code_q;   // Error code register
    logic        csr_err_q;    // Command status error flag
    logic [1:0]  ctrl_q;       // Control register
    logic        frozen_q;     // Halt display settled
    logic        ack_q;        // Wishbone ack
    logic [31:0] rdat_q;       // Wishbone read data
    logic [7:0]  lamp_d;       // Next lamp pattern
    logic        capture;      // Switch latch moment
    logic        running;      // Processor running a test
    logic        exer;         // Exerciser code selected
    logic        cls_valid;    // Code maps to a shown class
    logic [3:0]  cls;          // Class of incoming code
    logic        cls_flag;     // Code sets the error flag
    logic        hit;          // Error taken this cycle
    logic [3:0]  new_cls;      // Class of the taken error
    logic        req;          // New bus request
    logic        wr_ctrl;      // Control write
    logic        init_p;       // Software initialise

    // Two-stage synchronisers for pins
    always_ff @(posedge clk_i)
    begin
        sw_m_q <= sw_i;
        sw_s_q <= sw_m_q;
        hl_m_q <= head_loaded_i;
        hl_s_q <= hl_m_q;
    end

    assign capture = (state_q == ST_WAIT) && (wait_q == CAPTURE_WAIT);
    assign running = (state_q == ST_RUN);
    assign exer    = diag_mode_o && ((test_code_o == TC_EXER_FMT) || (test_code_o == TC_EXER));

    // Code classifier
    error_classifier u_class
    (
        .code_i  (err_code_i),
        .diag_i  (diag_mode_o),
        .valid_o (cls_valid),
        .class_o (cls),
        .flag_o  (cls_flag)
    );

    // Errors count only while a test runs
    always_comb
    begin
        hit     = 1'b0;
        new_cls = CL_NONE;
        if (running && err_valid_i && cls_valid)
        begin
            hit     = 1'b1;
            new_cls = cls;
        end
        else if (running && diag_mode_o && host_cable_fault_i)
        begin
            hit     = 1'b1;
            new_cls = CL_HOST;
        end
        else if (running && diag_mode_o && drive_cable_fault_i)
        begin
            hit     = 1'b1;
            new_cls = CL_DCAB;
        end
        else if (running && diag_mode_o && mismatch_i)
        begin
            hit     = 1'b1;
            new_cls = CL_PAT;
        end
    end

    // Bus decode
    assign req     = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_ctrl = req && wb_we_i && (wb_adr_i == OFS_CTRL) && wb_sel_i[0];
    assign init_p  = wr_ctrl && wb_dat_i[CTRL_INIT] && !diag_mode_o;

    // Controller state machine
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_WAIT;
            wait_q  <= 2'h0;
        end
        else
        begin
            case (state_q)
                ST_WAIT:
                begin
                    wait_q <= wait_q + 2'h1;
                    if (capture)
                        state_q <= ST_RUN;
                end
                ST_RUN:
                begin
                    if (hit && diag_mode_o)
                        state_q <= ST_HALT;
                end
                ST_HALT:
                    state_q <= ST_HALT;
                default:
                    state_q <= ST_WAIT;
            endcase
        end
    end

    // Switch latch at power-up, held until the next reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            diag_mode_o <= 1'b0;
            test_code_o <= 5'h00;
            sw8_q       <= 1'b0;
        end
        else if (capture)
        begin
            diag_mode_o <= |sw_s_q[SW_MODE_HI:SW_MODE_LO];
            test_code_o <= sw_s_q[SW_MODE_HI:SW_CODE_LO];
            sw8_q       <= sw_s_q[SW_DRIVE];
        end
    end

    // Drive selection and exerciser alternation
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_sel_o     <= 1'b0;
            exercise_both_o <= 1'b0;
        end
        else if (capture)
        begin
            // First pass starts on the switch eight drive in diagnostic mode, on drive zero in normal mode
            drive_sel_o     <= |sw_s_q[SW_MODE_HI:SW_MODE_LO] && sw_s_q[SW_DRIVE];
            exercise_both_o <= 1'b0;
        end
        else if (running && exer)
        begin
            exercise_both_o <= sw8_q;
            if (!sw8_q)
                drive_sel_o <= 1'b0;
            else if (pass_done_i)
                drive_sel_o <= !drive_sel_o;
        end
    end

    // Error class, later errors replace it in normal mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            class_q <= CL_NONE;
        else if (hit)
            class_q <= new_cls;
        else if (init_p)
            class_q <= CL_NONE;
    end

    // Error code register and flag, set wins over initialise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_code_q <= 8'h00;
            csr_err_q  <= 1'b0;
        end
        else
        begin
            // An ignored code beside a fault pulse is never recorded
            if (hit && err_valid_i && cls_valid)
                err_code_q <= err_code_i;
            else if (init_p)
                err_code_q <= 8'h00;
            if (hit && err_valid_i && cls_valid && cls_flag)
                csr_err_q <= 1'b1;
            else if (init_p)
                csr_err_q <= 1'b0;
        end
    end

    // Lamp pattern selection, a halt outranks the echo pattern
    always_comb
    begin
        lamp_d = 8'h00;
        if (!ctrl_q[CTRL_LAMP_EN] || (state_q == ST_WAIT))
            lamp_d = 8'h00;
        else if (!diag_mode_o)
            lamp_d = {1'b1, host_wait_i, write_busy_i, read_busy_i, class_q};
        else if (state_q == ST_HALT)
            lamp_d = {4'h0, class_q};
        else if (test_code_o == TC_ECHO)
            lamp_d = sw_s_q;
        else
            lamp_d = {selftest_busy_i, selftest_busy_i,
                      write_busy_i, read_busy_i,
                      density_i, 1'b0, drive_sel_o};
    end

    // Lamp registers freeze once the halt display settles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lamp_o      <= 8'h00;
            run_lamp_o  <= 1'b1;
            drive_act_o <= 2'b00;
            frozen_q    <= 1'b0;
        end
        else
        begin
            frozen_q   <= (state_q == ST_HALT);
            run_lamp_o <= (state_q != ST_HALT);
            if (!frozen_q)
            begin
                lamp_o <= lamp_d;
                if (state_q == ST_HALT)
                    drive_act_o <= drive_sel_o ? 2'b10 : 2'b01;
                else
                    drive_act_o <= hl_s_q;
            end
        end
    end

    // Wishbone slave, ack one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RST;
        end
        else
        begin
            ack_q <= req;
            if (wr_ctrl)
                ctrl_q[CTRL_LAMP_EN] <= wb_dat_i[CTRL_LAMP_EN];
            // Unmapped offsets read as zero
            if (req && (wb_adr_i == OFS_CTRL))
                rdat_q <= {30'h0, ctrl_q[CTRL_LAMP_EN], 1'b0};
            else if (req && (wb_adr_i == OFS_STAT))
                rdat_q <= {19'h0, class_q, (state_q == ST_HALT), diag_mode_o,
                           exercise_both_o, drive_sel_o, test_code_o};
            else if (req && (wb_adr_i == OFS_CODE))
                rdat_q <= {24'h0, err_code_q};
            else if (req && (wb_adr_i == OFS_CSR))
                rdat_q <= {16'h0, csr_err_q, 15'h0};
            else if (req)
                rdat_q <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_mode_select:  assert property (capture |=> diag_mode_o == $past(|sw_s_q[7:5]))
        else $error("mode not taken from top switches");
    chk_code_select:  assert property (capture |=> test_code_o == $past(sw_s_q[7:3]))
        else $error("test code not taken from switches");
    chk_code_hold:    assert property ((state_q != ST_WAIT) |=> $stable(test_code_o))
        else $error("test code changed after power-up");
    chk_echo_lamps:   assert property ((running && diag_mode_o && test_code_o == TC_ECHO
                                        && ctrl_q[1]) |=> lamp_o == $past(sw_s_q))
        else $error("echo lamps do not follow switches");
    chk_single_drive: assert property ((running && diag_mode_o && !exer) |-> drive_sel_o == sw8_q)
        else $error("single test drive wrong");
    chk_exer_drive:   assert property ((running && exer && !sw8_q) |-> ##1 !drive_sel_o)
        else $error("exerciser left drive zero");
    chk_selftest_off: assert property ((running && diag_mode_o && test_code_o != TC_ECHO
                                        && !selftest_busy_i) |=> lamp_o[7:6] == 2'b00)
        else $error("lamps one two lit without self-test");
    chk_rw_lamps:     assert property ((running && ctrl_q[1] && test_code_o != TC_ECHO && !hit)
                                       |=> lamp_o[5:4] == $past({write_busy_i, read_busy_i}))
        else $error("write read lamps wrong");
    chk_halt_show:    assert property ((hit && diag_mode_o) |-> ##2 (!run_lamp_o
                                       && (!ctrl_q[1] || lamp_o[3:0] == $past(new_cls, 2))))
        else $error("halt did not show class");
    chk_act_hold:     assert property (frozen_q |-> drive_act_o == (drive_sel_o ? 2'b10 : 2'b01))
        else $error("failed drive lamp not lit");
    chk_read_lost:    assert property ((running && err_valid_i && err_code_i == EC_NORD)
                                       |=> class_q == CL_RDAT)
        else $error("read lost class wrong");
    chk_no_unas:      assert property (diag_mode_o |-> (class_q != CL_UNAS2 && class_q != CL_UNAS7))
        else $error("unassigned class shown");
    chk_no_host_err:  assert property ((diag_mode_o && err_valid_i && (err_code_i == EC_PAR
                                        || err_code_i == EC_NXM)) |-> !hit)
        else $error("host error raised in diagnostics");
    chk_code_record:  assert property ((hit && err_valid_i && cls_valid)
                                       |=> err_code_q == $past(err_code_i))
        else $error("error code not recorded");
    chk_flag_skip:    assert property ((!csr_err_q && err_valid_i && (err_code_i == EC_HOME1
                                        || err_code_i == EC_HCRC)) |=> !csr_err_q)
        else $error("error flag set by exempt code");
    chk_halt_freeze:  assert property (frozen_q |=> ($stable(lamp_o) && $stable(class_q)))
        else $error("halt display changed");

    cov_halt:   cover property (hit && diag_mode_o ##2 frozen_q);
    cov_echo:   cover property (running && test_code_o == TC_ECHO ##1 $changed(lamp_o));
    cov_toggle: cover property (running && exer && sw8_q && pass_done_i);
endmodule

// ==== tb/panel_drive_model.sv ====
// Operator switch bank and drive head model facing the diagnostic block
`timescale 1ns/10ps
module panel_drive_model
(
    // Clock
    input  wire logic       clk_i,
    // Operator setting and drive lamps from the block
    input  wire logic [7:0] sw_set_i,
    input  wire logic [1:0] drive_act_i,
    // Panel and drive pins
    output logic      [7:0] sw_o,
    output logic      [1:0] head_loaded_o
);
    logic [7:0] sw_q   = 8'h00; // Rocker positions
    logic [1:0] head_q = 2'h0;  // Head load state per drive

    // Switches are only moved around a reset, or live during the echo test
    always_ff @(posedge clk_i)
    begin
        sw_q <= sw_set_i;
    end

    // A drive loads its head one cycle after its activity lamp lights
    always_ff @(posedge clk_i)
    begin
        head_q <= drive_act_i;
    end

    assign sw_o          = sw_q;
    assign head_loaded_o = head_q;
endmodule

// ==== tb/tb_diag_mode_select_and_error_display.sv ====
// Self-checking bench for the diagnostic mode select and error display
`timescale 1ns/10ps
module tb_diag_mode_select_and_error_display;
    import diag_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [7:0] sw_set = 8'h01, sw_i, err_code_i = 8'h00, lamp_o;
    logic [1:0] head_loaded_i, density_i = 2'h2, drive_act_o;
    logic selftest_busy_i = 0, write_busy_i = 1, read_busy_i = 0, host_wait_i = 1, pass_done_i = 0;
    logic err_valid_i = 0, mismatch_i = 0, host_cable_fault_i = 0, drive_cable_fault_i = 0;
    logic run_lamp_o, diag_mode_o, drive_sel_o, exercise_both_o;
    logic [4:0] test_code_o;
    int failures = 0, cmp_count = 0;
    // Entries: event kind, octal code as byte, expected class
    localparam logic [13:0] TBL [24] = '{14'h008D, 14'h010D, 14'h018D, 14'h028D, 14'h0389, 14'h0401,
        14'h048A, 14'h0509, 14'h0589, 14'h0686, 14'h0709, 14'h0789, 14'h0808, 14'h090B, 14'h0B05,
        14'h0B8F, 14'h0D0B, 14'h0D8B, 14'h0E0C, 14'h0F01, 14'h0F8F, 14'h1003, 14'h2004, 14'h300E};
    localparam logic [7:0] IGN [7] = '{8'h88, 8'hE8, 8'h60, 8'h20, 8'hA0, 8'hA8, 8'h98};

    always #4 clk_i = ~clk_i;

    diag_mode_select_and_error_display dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sw_i(sw_i),
        .head_loaded_i(head_loaded_i), .selftest_busy_i(selftest_busy_i), .write_busy_i(write_busy_i),
        .read_busy_i(read_busy_i), .host_wait_i(host_wait_i), .density_i(density_i),
        .pass_done_i(pass_done_i), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
        .mismatch_i(mismatch_i), .host_cable_fault_i(host_cable_fault_i),
        .drive_cable_fault_i(drive_cable_fault_i), .lamp_o(lamp_o), .run_lamp_o(run_lamp_o),
        .drive_act_o(drive_act_o), .diag_mode_o(diag_mode_o), .test_code_o(test_code_o),
        .drive_sel_o(drive_sel_o), .exercise_both_o(exercise_both_o));

    panel_drive_model partner (.clk_i(clk_i), .sw_set_i(sw_set), .drive_act_i(drive_act_o),
        .sw_o(sw_i), .head_loaded_o(head_loaded_i));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Closing report
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic Wishbone cycle, entered just after a rising edge
    task automatic wb_io(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] q);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            failures++;
            give_verdict();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Power-up with a switch setting
    task automatic power_up(input logic [7:0] sw);
        sw_set <= sw;
        rst_i  <= 1'b1;
        ticks(6);
        rst_i <= 1'b0;
        ticks(5);
    endtask

    // One-cycle error event of the given kind
    task automatic fire(input logic [1:0] kind, input logic [7:0] code);
        err_valid_i         <= (kind == 2'h0);
        host_cable_fault_i  <= (kind == 2'h1);
        drive_cable_fault_i <= (kind == 2'h2);
        mismatch_i          <= (kind == 2'h3);
        err_code_i          <= code;
        @(posedge clk_i);
        {err_valid_i, host_cable_fault_i, drive_cable_fault_i, mismatch_i} <= 4'h0;
        ticks(3);
    endtask

    initial
    begin
        // Normal mode: error shown without halt, cleared by init, lamps blanked
        power_up(8'h01);
        check(diag_mode_o, 1'b0);
        fire(2'h0, EC_NORD);
        check(lamp_o, 8'hEA);
        check(run_lamp_o, 1'b1);
        wb_io(1'b0, OFS_CSR, 32'h0, rd);
        check(rd[CSR_ERR], 1'b1);
        wb_io(1'b1, OFS_CTRL, 32'h3, rd);
        ticks(2);
        check(lamp_o, 8'hE0);
        wb_io(1'b1, OFS_CTRL, 32'h0, rd);
        ticks(2);
        check(lamp_o, 8'h00);
        wb_io(1'b0, OFS_CTRL, 32'h0, rd);
        check(rd, 32'h0);
        wb_io(1'b0, 4'h2, 32'h0, rd);
        check(rd, 32'h0);
        $display("normal mode test done");
        // Echo test follows live switches, six and seven included
        power_up(8'h81);
        check(test_code_o, TC_ECHO);
        check(lamp_o, 8'h81);
        sw_set <= 8'h87;
        ticks(5);
        check(lamp_o, 8'h87);
        $display("echo test done");
        // Exerciser alternates drives on each pass with switch eight, stays on drive zero without it; host codes ignored
        power_up(8'hF9);
        check({exercise_both_o, drive_sel_o}, 2'h3);
        pass_done_i <= 1'b1;
        @(posedge clk_i);
        pass_done_i <= 1'b0;
        ticks(3);
        check(drive_sel_o, 1'b0);
        power_up(8'hF8);
        check({exercise_both_o, drive_sel_o}, 2'h0);
        check(lamp_o, 8'h28);
        for (int i = 0; i < 7; i++)
        begin
            fire(2'h0, IGN[i]);
            check(run_lamp_o, 1'b1);
        end
        $display("exerciser test done");
        // Each assigned error class halts and holds
        for (int i = 0; i < 24; i++)
        begin
            power_up(8'hC1);
            check(drive_sel_o, 1'b1);
            fire(TBL[i][13:12], TBL[i][11:4]);
            check(lamp_o, {4'h0, TBL[i][3:0]});
            check({run_lamp_o, drive_act_o}, 3'h2);
            wb_io(1'b0, OFS_CODE, 32'h0, rd);
            if (TBL[i][13:12] == 2'h0)
                check(rd[7:0], TBL[i][11:4]);
            wb_io(1'b0, OFS_CSR, 32'h0, rd);
            check(rd[CSR_ERR], (TBL[i][13:12] == 2'h0) && (TBL[i][11:4] != EC_HOME1));
            fire(2'h0, EC_DCRC);
            check({run_lamp_o, drive_act_o, lamp_o}, {3'h2, 4'h0, TBL[i][3:0]});
        end
        $display("error class test done");
        give_verdict();
    end
endmodule
